// ===== design/aac_consts.svh
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH

// Register indices on the device control port.
`define AAC_REG_CONTROL     7'h3D
`define AAC_REG_SOURCE      7'h3E
`define AAC_REG_DATA        7'h3C

// Control register fields.
`define AAC_CTL_ENA_BIT     15
`define AAC_CTL_CVT_BIT     14
`define AAC_CTL_RATE_MSB    4
`define AAC_CTL_RATE_LSB    0
`define AAC_RATE_MANUAL     5'h00

// Source register fields.
`define AAC_SRC_SUPPLY_BIT  8
`define AAC_SRC_PIN2_BIT    1
`define AAC_SRC_PIN1_BIT    0

// Data register fields.
`define AAC_DAT_TAG_MSB     13
`define AAC_DAT_TAG_LSB     12
`define AAC_TAG_NONE        2'h0
`define AAC_TAG_PIN1        2'h1
`define AAC_TAG_PIN2        2'h2
`define AAC_TAG_SUPPLY      2'h3

// Reset values.
`define AAC_RST_16          16'h0000
`define AAC_RST_12          12'h000

// Rate timer: one rate step per period of 16 Hz; the tick fires after rate steps.
`define AAC_CLK_HZ          25000000
`define AAC_STEP_HZ         16
`define AAC_PERIOD_CYC      (`AAC_CLK_HZ / `AAC_STEP_HZ)
`define AAC_CNT_W           21

`endif

// ===== design/aac_pkg.sv
package aac_pkg;
    // Sequencer states.
    typedef enum logic [1:0] {
        AAC_IDLE = 2'b00,
        AAC_REQ  = 2'b01,
        AAC_WAIT = 2'b10
    } aac_state_t;

    // Converter input selection.
    typedef enum logic [1:0] {
        AAC_IN_NONE   = 2'b00,
        AAC_IN_PIN1   = 2'b01,
        AAC_IN_PIN2   = 2'b10,
        AAC_IN_SUPPLY = 2'b11
    } aac_input_t;
endpackage : aac_pkg

// ===== design/aac_result_store.sv
`timescale 1ns/100ps
`include "aac_consts.svh"

module aac_result_store (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Write side.
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_tag,
    input  wire logic [11:0] wr_data,
    // Registered read side.
    output logic      [15:0] rd_word
);
    logic [1:0]  tag_ff;
    logic [11:0] data_ff;

    // Each new result overwrites the previous one.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tag_ff  <= `AAC_TAG_NONE;
            data_ff <= `AAC_RST_12;
        end else if (wr_en) begin
            tag_ff  <= wr_tag;
            data_ff <= wr_data;
        end
    end

    // The readable word is formed in a register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_word <= `AAC_RST_16;
        end else begin
            rd_word <= {2'h0, tag_ff, data_ff};
        end
    end
endmodule : aac_result_store

// ===== design/aac_sequencer.sv
`timescale 1ns/100ps
`include "aac_consts.svh"

module aac_sequencer
    import aac_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst_b,
    // Device control port register access.
    input  wire logic                reg_wr,
    input  wire logic [6:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    output logic      [15:0]         reg_rdata,
    // Shared converter core.
    output logic                     conv_start,
    output aac_pkg::aac_input_t      conv_input,
    input  wire logic                conv_done,
    input  wire logic [11:0]         conv_result,
    // Touch panel requester.
    input  wire logic                touch_req,
    output logic                     touch_grant,
    // Completion event.
    output logic                     conv_event
);
    import aac_pkg::*;

    logic                 ena_ff;
    logic                 cvt_ff;
    logic [4:0]           rate_ff;
    logic                 sel_supply_ff;
    logic                 sel_pin2_ff;
    logic                 sel_pin1_ff;
    logic [`AAC_CNT_W-1:0] tmr_ff;
    logic [4:0]           step_ff;
    logic                 pend_ff;
    aac_state_t           state_ff;
    aac_state_t           nxt_state;
    aac_input_t           last_ff;
    aac_input_t           nxt_input;
    logic                 touch_busy_ff;
    logic [15:0]          data_word;
    logic                 manual;
    logic                 run_auto;
    logic                 tick;
    logic                 ctl_wr;
    logic                 src_wr;
    logic                 any_sel;

    assign manual   = (rate_ff == `AAC_RATE_MANUAL);
    assign run_auto = ena_ff && cvt_ff && !manual;
    assign ctl_wr   = reg_wr && (reg_addr == `AAC_REG_CONTROL);
    assign src_wr   = reg_wr && (reg_addr == `AAC_REG_SOURCE);
    assign any_sel  = sel_supply_ff || sel_pin2_ff || sel_pin1_ff;

    // Control register; manual conversion bit self-clears after its request.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ena_ff  <= 1'b0;
            cvt_ff  <= 1'b0;
            rate_ff <= 5'h00;
        end else if (ctl_wr) begin
            ena_ff  <= reg_wdata[`AAC_CTL_ENA_BIT];
            cvt_ff  <= reg_wdata[`AAC_CTL_CVT_BIT];
            rate_ff <= reg_wdata[`AAC_CTL_RATE_MSB:`AAC_CTL_RATE_LSB];
        end else if (manual && cvt_ff) begin
            cvt_ff  <= 1'b0;
        end
    end

    // Source register: independent enables per input.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_supply_ff <= 1'b0;
            sel_pin2_ff   <= 1'b0;
            sel_pin1_ff   <= 1'b0;
        end else if (src_wr) begin
            sel_supply_ff <= reg_wdata[`AAC_SRC_SUPPLY_BIT];
            sel_pin2_ff   <= reg_wdata[`AAC_SRC_PIN2_BIT];
            sel_pin1_ff   <= reg_wdata[`AAC_SRC_PIN1_BIT];
        end
    end

    // Rate timer: counts 16 Hz periods, fires after rate of them.
    always_ff @(posedge clk) begin
        if (!rst_b || !run_auto) begin
            tmr_ff  <= '0;
            step_ff <= 5'h00;
            tick    <= 1'b0;
        end else if (tmr_ff == `AAC_CNT_W'(`AAC_PERIOD_CYC - 1)) begin
            tmr_ff <= '0;
            if (step_ff == 5'(rate_ff - 5'h01)) begin
                step_ff <= 5'h00;
                tick    <= 1'b1;
            end else begin
                step_ff <= 5'(step_ff + 5'h01);
                tick    <= 1'b0;
            end
        end else begin
            tmr_ff <= `AAC_CNT_W'(tmr_ff + 1'b1);
            tick   <= 1'b0;
        end
    end

    // Pending trigger, set by a manual write or a timer tick.
    always_ff @(posedge clk) begin
        if (!rst_b || !ena_ff || (!cvt_ff && !manual)) begin
            pend_ff <= 1'b0;
        end else if ((manual && cvt_ff) || tick) begin
            pend_ff <= any_sel;
        end else if (state_ff == AAC_IDLE && nxt_state == AAC_REQ) begin
            // Consumed by the start, so one trigger cannot cause a second start and a waiting touch request can be granted.
            pend_ff <= 1'b0;
        end
    end

    // Next enabled input after the last one measured.
    always_comb begin
        nxt_input = AAC_IN_NONE;
        case (last_ff)
            AAC_IN_PIN1: begin
                nxt_input = sel_pin2_ff ? AAC_IN_PIN2 :
                            sel_supply_ff ? AAC_IN_SUPPLY :
                            sel_pin1_ff ? AAC_IN_PIN1 : AAC_IN_NONE;
            end
            AAC_IN_PIN2: begin
                nxt_input = sel_supply_ff ? AAC_IN_SUPPLY :
                            sel_pin1_ff ? AAC_IN_PIN1 :
                            sel_pin2_ff ? AAC_IN_PIN2 : AAC_IN_NONE;
            end
            default: begin
                nxt_input = sel_pin1_ff ? AAC_IN_PIN1 :
                            sel_pin2_ff ? AAC_IN_PIN2 :
                            sel_supply_ff ? AAC_IN_SUPPLY : AAC_IN_NONE;
            end
        endcase
    end

    // Round-robin pointer; restarts when the converter is disabled.
    always_ff @(posedge clk) begin
        if (!rst_b || !ena_ff) begin
            last_ff <= AAC_IN_SUPPLY;
        end else if (state_ff == AAC_IDLE && nxt_state == AAC_REQ) begin
            last_ff <= nxt_input;
        end
    end

    // Touch panel holds the converter from grant to its done.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            touch_busy_ff <= 1'b0;
        end else if (touch_grant) begin
            touch_busy_ff <= 1'b1;
        end else if (conv_done) begin
            touch_busy_ff <= 1'b0;
        end
    end

    // Touch wins only when no auxiliary request waits.
    assign touch_grant = touch_req && !touch_busy_ff && state_ff == AAC_IDLE
                         && !pend_ff;

    // Sequencer issues one conversion per trigger.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            AAC_IDLE: begin
                if (pend_ff && ena_ff && any_sel && !touch_busy_ff
                    && !((manual && cvt_ff) || tick)) begin
                    nxt_state = AAC_REQ;
                end
            end
            AAC_REQ: begin
                nxt_state = AAC_WAIT;
            end
            AAC_WAIT: begin
                if (conv_done) begin
                    nxt_state = AAC_IDLE;
                end
            end
            default: begin
                nxt_state = AAC_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= AAC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // One start pulse and the input it measures.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_start <= 1'b0;
            conv_input <= AAC_IN_NONE;
        end else begin
            conv_start <= (state_ff == AAC_IDLE && nxt_state == AAC_REQ);
            if (state_ff == AAC_IDLE && nxt_state == AAC_REQ) begin
                conv_input <= nxt_input;
            end
        end
    end

    // Completion event for each auxiliary conversion.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_event <= 1'b0;
        end else begin
            conv_event <= (state_ff == AAC_WAIT) && conv_done;
        end
    end

    // Twelve-bit result store with its source tag.
    aac_result_store u_store (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   ((state_ff == AAC_WAIT) && conv_done),
        .wr_tag  (conv_input),
        .wr_data (conv_result),
        .rd_word (data_word)
    );

    // Register read mux; unmapped indices read zero.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= `AAC_RST_16;
        end else begin
            case (reg_addr)
                `AAC_REG_CONTROL: reg_rdata <= {ena_ff, cvt_ff, 9'h000, rate_ff};
                `AAC_REG_SOURCE:  reg_rdata <= {7'h00, sel_supply_ff, 6'h00,
                                                sel_pin2_ff, sel_pin1_ff};
                `AAC_REG_DATA:    reg_rdata <= data_word;
                default:          reg_rdata <= `AAC_RST_16;
            endcase
        end
    end

    // Disabled converter never starts a conversion.
    no_conv_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !ena_ff |-> ##1 !conv_start) else $error("start while disabled");

    // Manual bit reads zero one cycle after it was set.
    manual_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (manual && cvt_ff && !ctl_wr) |=> !cvt_ff) else $error("cvt not cleared");

    // Start is a single pulse.
    one_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        conv_start |=> !conv_start) else $error("burst start");

    // Started input is never the none selection.
    input_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
        conv_start |-> conv_input != AAC_IN_NONE) else $error("bad input");

    // Event follows a done in wait by one cycle.
    done_event_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_ff == AAC_WAIT && conv_done) |=> conv_event) else $error("no event");

    // Grants never overlap an auxiliary conversion.
    grant_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
        touch_grant |-> state_ff == AAC_IDLE) else $error("grant overlap");

    // Disabling auto mode stops the timer.
    timer_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        !run_auto |=> tmr_ff == '0 && !tick) else $error("timer runs");

    // Tag is captured with the result.
    tag_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_ff == AAC_WAIT && conv_done) |-> ##2
        data_word[13:12] == $past(conv_input, 2)) else $error("tag");
endmodule : aac_sequencer

// ===== test/test_aux_adc_conversion_sequencer.sv
`timescale 1ns/100ps
`include "aac_consts.svh"

module test_aux_adc_conversion_sequencer;
    import aac_pkg::*;

    logic        clk;
    logic        rst_b;
    logic        reg_wr;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        conv_start;
    aac_input_t  conv_input;
    logic        conv_done;
    logic [11:0] conv_result;
    logic        touch_req;
    logic        touch_grant;
    logic        conv_event;
    logic [3:0]  busy_cnt;
    aac_input_t  last_input;
    int          n_starts;
    int          failures;
    int          n_checks;

    aac_sequencer dut_u (
        .clk         (clk),
        .rst_b       (rst_b),
        .reg_wr      (reg_wr),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_rdata   (reg_rdata),
        .conv_start  (conv_start),
        .conv_input  (conv_input),
        .conv_done   (conv_done),
        .conv_result (conv_result),
        .touch_req   (touch_req),
        .touch_grant (touch_grant),
        .conv_event  (conv_event)
    );

    // Clock at 25 MHz.
    always #20 clk = ~clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One register write: strobe held for exactly one edge.
    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Register read: data is registered one cycle after the address.
    task automatic rd_chk(input string what, input logic [6:0] addr, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= addr;
        @(posedge clk);
        @(posedge clk);
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd_chk

    // Lets cycles pass and checks that no measurement was started.
    task automatic idle_chk(input string what, input int cycles);
        int s0;
        s0 = n_starts;
        repeat (cycles) @(posedge clk);
        chk(what, 16'h0000, 16'(n_starts - s0));
    endtask : idle_chk

    // One manual trigger and the checks on its single measurement.
    task automatic trig(input aac_input_t exp_in);
        int   s0;
        logic seen;
        s0   = n_starts;
        seen = 1'b0;
        wr(`AAC_REG_CONTROL, 16'hC000);
        rd_chk("cvt self clear", `AAC_REG_CONTROL, 16'h8000);
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge clk);
            #1;
            if (conv_event === 1'b1) seen = 1'b1;
        end
        chk("event", 16'h0001, {15'h0000, seen});
        repeat (3) @(posedge clk);
        chk("starts", 16'h0001, 16'(n_starts - s0));
        chk("input", {14'h0000, exp_in}, {14'h0000, last_input});
        rd_chk("data", `AAC_REG_DATA, {2'b00, exp_in, 12'h5A0 + 12'(s0)});
    endtask : trig

    // Converter core: busy five cycles after a start or a touch grant.
    always @(posedge clk) begin
        conv_done <= 1'b0;
        if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
            if (busy_cnt == 4'h1) conv_done <= 1'b1;
        end
        if (conv_start === 1'b1 || touch_grant === 1'b1) begin
            chk("converter free", 16'h0000, {12'h000, busy_cnt});
            busy_cnt <= 4'h5;
        end
        if (conv_start === 1'b1) begin
            conv_result <= 12'h5A0 + 12'(n_starts);
            last_input  <= conv_input;
            n_starts++;
        end
    end

    // Watchdog against a hang.
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end

    // Main sequence.
    initial begin
        aac_input_t seq [5];
        clk = 1'b0; rst_b = 1'b0; reg_wr = 1'b0; reg_addr = 7'h00; reg_wdata = 16'h0000;
        conv_done = 1'b0; conv_result = 12'h000; touch_req = 1'b0; busy_cnt = 4'h0;
        last_input = AAC_IN_NONE; n_starts = 0; failures = 0; n_checks = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("control reset", `AAC_REG_CONTROL, 16'h0000);
        rd_chk("source reset", `AAC_REG_SOURCE, 16'h0000);
        rd_chk("data reset", `AAC_REG_DATA, 16'h0000);
        rd_chk("unmapped", 7'h10, 16'h0000);
        wr(`AAC_REG_SOURCE, 16'h0103);
        rd_chk("source rw", `AAC_REG_SOURCE, 16'h0103);
        // Trigger with the converter disabled, then with no input enabled.
        wr(`AAC_REG_CONTROL, 16'h4000);
        idle_chk("no start disabled", 40);
        wr(`AAC_REG_SOURCE, 16'h0000);
        wr(`AAC_REG_CONTROL, 16'hC000);
        idle_chk("no start no input", 40);
        // All inputs enabled: visited in turn.
        wr(`AAC_REG_SOURCE, 16'h0103);
        seq = '{AAC_IN_PIN1, AAC_IN_PIN2, AAC_IN_SUPPLY, AAC_IN_PIN1, AAC_IN_PIN2};
        for (int i = 0; i < 4; i++) trig(seq[i]);
        // Second pin and supply only, with a touch request taking the converter.
        wr(`AAC_REG_SOURCE, 16'h0102);
        seq = '{AAC_IN_PIN2, AAC_IN_SUPPLY, AAC_IN_PIN2, AAC_IN_SUPPLY, AAC_IN_PIN2};
        for (int i = 0; i < 5; i++) begin
            if (i == 3) begin
                @(posedge clk);
                touch_req <= 1'b1;
                for (int k = 0; k < 40 && touch_grant !== 1'b1; k++) begin
                    @(posedge clk);
                    #1;
                end
                chk("touch grant", 16'h0001, {15'h0000, touch_grant});
                @(posedge clk);
                touch_req <= 1'b0;
            end
            trig(seq[i]);
        end
        // Automatic mode keeps the conversion bit; clearing it stops triggers.
        wr(`AAC_REG_CONTROL, 16'hC001);
        rd_chk("auto cvt kept", `AAC_REG_CONTROL, 16'hC001);
        wr(`AAC_REG_CONTROL, 16'h8001);
        rd_chk("auto stopped", `AAC_REG_CONTROL, 16'h8001);
        idle_chk("no start stopped", 60);
        // Disabling restarts the pointer at the first enabled input.
        wr(`AAC_REG_CONTROL, 16'h0000);
        wr(`AAC_REG_SOURCE, 16'h0103);
        trig(AAC_IN_PIN1);
        summarize();
    end
endmodule : test_aux_adc_conversion_sequencer
